// File: design/emo_ctrl.sv
// emulated encoder output control: registers, direction, index, overspeed
`timescale 1ns/1ns
`default_nettype none
`include "emo_defines.svh"
module emo_ctrl
  import emo_pkg::*;
#(
  parameter int POS_W = 16,
  parameter int VEL_W = 16,
  parameter int PW_W = 16
) (
  input wire logic i_clk, // control clock, 100 MHz
  input wire logic i_rstn, // sync reset, active low
  input wire logic i_ce, // clock enable, freezes state when low
  input wire logic [11:0] i_reg_addr, // parameter address
  input wire logic i_reg_wr, // write strobe
  input wire logic i_reg_rd, // read strobe
  input wire logic [15:0] i_reg_wdata, // write data
  output logic [15:0] o_reg_rdata, // read data, one cycle after strobe
  input wire logic i_drive_direction_bit, // drive-wide direction
  input wire logic [POS_W-1:0] i_lines_per_rev_setting, // lines/rev
  input wire logic [PW_W-1:0] i_output_pulse_width_setting, // cycles
  input wire logic [POS_W-1:0] i_index_offset_setting, // offset in rev
  input wire logic [31:0] i_index_turn_setting, // turn of abs index
  input wire logic i_fb_step, // feedback moved one line
  input wire logic i_fb_up, // that move raised feedback
  input wire logic [POS_W-1:0] i_rev_pos, // position within one rev
  input wire logic [31:0] i_turn, // present turn number
  input wire logic i_phys_index, // physical index from encoder
  input wire logic [VEL_W-1:0] i_velocity, // motor speed, rev/s magnitude
  output logic o_pulse_a, // emulated pulse output line a
  output logic o_pulse_b, // emulated pulse output line b
  output logic o_pulse_index, // emulated pulse output index
  output logic o_output_overspeed_fault // overspeed fault level
);
  localparam int PROD_W = VEL_W + POS_W + PW_W + 3;

  ////////////////////////////////////////////////////////////////////////
  logic dir_q, dir_d, chk_q, chk_d;
  logic [3:0] mode_q, mode_d;
  logic [15:0] rdata_q, rdata_d;

  // parameter writes; a mode above 14 is refused and the old mode stays
  always_comb begin
    dir_d = dir_q;
    chk_d = chk_q;
    mode_d = mode_q;
    rdata_d = rdata_q;
    if (i_reg_wr) begin
      if (i_reg_addr == `EMO_ADDR_DIR) begin
        dir_d = i_reg_wdata[0];
      end else if (i_reg_addr == `EMO_ADDR_MODE) begin
        if (i_reg_wdata <= 16'(`EMO_MODE_MAX)) begin
          mode_d = i_reg_wdata[3:0];
        end
      end else if (i_reg_addr == `EMO_ADDR_CHK) begin
        chk_d = i_reg_wdata[0];
      end
    end
    if (i_reg_rd) begin
      if (i_reg_addr == `EMO_ADDR_DIR) begin
        rdata_d = {15'h0000, dir_q};
      end else if (i_reg_addr == `EMO_ADDR_MODE) begin
        rdata_d = {12'h000, mode_q};
      end else if (i_reg_addr == `EMO_ADDR_CHK) begin
        rdata_d = {15'h0000, chk_q};
      end else begin
        rdata_d = 16'h0000;
      end
    end
  end

  // parameter registers
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      dir_q <= `EMO_DIR_RST;
      chk_q <= `EMO_CHK_RST;
      mode_q <= `EMO_MODE_RST;
      rdata_q <= 16'h0000;
    end else if (i_ce) begin
      dir_q <= dir_d;
      chk_q <= chk_d;
      mode_q <= mode_d;
      rdata_q <= rdata_d;
    end
  end
  assign o_reg_rdata = rdata_q;

  ////////////////////////////////////////////////////////////////////////
  emo_fmt_t fmt;
  emo_idx_t idx;

  // mode decode; inputs, general i/o and feedback modes give no output
  always_comb begin
    fmt = EMO_FMT_OFF;
    idx = EMO_IDX_NONE;
    case (mode_q)
      4'h1: begin fmt = EMO_FMT_QUAD; idx = EMO_IDX_REV; end
      4'h2: begin fmt = EMO_FMT_QUAD; idx = EMO_IDX_ABS; end
      4'h6: begin fmt = EMO_FMT_STEPDIR; idx = EMO_IDX_REV; end
      4'h7: begin fmt = EMO_FMT_STEPDIR; idx = EMO_IDX_ABS; end
      4'h8: begin fmt = EMO_FMT_CWCCW; idx = EMO_IDX_REV; end
      4'h9: begin fmt = EMO_FMT_CWCCW; idx = EMO_IDX_ABS; end
      4'hC: begin fmt = EMO_FMT_QUAD; idx = EMO_IDX_PASS; end
      4'hD: begin fmt = EMO_FMT_STEPDIR; idx = EMO_IDX_PASS; end
      4'hE: begin fmt = EMO_FMT_CWCCW; idx = EMO_IDX_PASS; end
      default: begin fmt = EMO_FMT_OFF; idx = EMO_IDX_NONE; end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  logic eff_dir, out_up;

  // the output counts with feedback when the two bits agree
  assign eff_dir = i_drive_direction_bit ^ dir_q;
  assign out_up = i_fb_up ^ eff_dir;

  emo_pulse_gen #(
    .PW_W(PW_W)
  ) u_gen (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_ce(i_ce),
    .i_fmt(fmt),
    .i_pw(i_output_pulse_width_setting),
    .i_step(i_fb_step),
    .i_up(out_up),
    .o_a(o_pulse_a),
    .o_b(o_pulse_b),
    .o_busy()
  );

  ////////////////////////////////////////////////////////////////////////
  logic hit_q, hit_d, idx_q, idx_d, hit_now;

  // index on the cycle the offset is first reached, not while it sits
  always_comb begin
    hit_now = (i_rev_pos == i_index_offset_setting);
    hit_d = hit_now;
    idx_d = 1'b0;
    case (idx)
      EMO_IDX_REV: idx_d = hit_now & ~hit_q;
      EMO_IDX_ABS: begin
        idx_d = hit_now & ~hit_q & (i_turn == i_index_turn_setting);
      end
      EMO_IDX_PASS: idx_d = i_phys_index;
      default: idx_d = 1'b0;
    endcase
  end

  // index registers
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      hit_q <= 1'b0;
      idx_q <= 1'b0;
    end else if (i_ce) begin
      hit_q <= hit_d;
      idx_q <= idx_d;
    end
  end
  assign o_pulse_index = idx_q;

  ////////////////////////////////////////////////////////////////////////
  logic [PROD_W-1:0] need_q, need_d;
  logic flt_q, flt_d;
  logic [PW_W-1:0] pw_eff;

  // limit: vel * lines * edges * width cycles must fit in one second;
  // multiplying avoids a divider at the cost of one pipeline stage
  always_comb begin
    pw_eff = (i_output_pulse_width_setting == '0) ? PW_W'(1)
           : i_output_pulse_width_setting;
    need_d = PROD_W'(i_velocity) * PROD_W'(i_lines_per_rev_setting)
           * PROD_W'(pw_eff) * PROD_W'(`EMO_EDGES_PER_LINE);
    flt_d = chk_q && (fmt != EMO_FMT_OFF)
          && (need_q > PROD_W'(`EMO_CLK_HZ));
  end

  // overspeed registers
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      need_q <= '0;
      flt_q <= 1'b0;
    end else if (i_ce) begin
      need_q <= need_d;
      flt_q <= flt_d;
    end
  end
  assign o_output_overspeed_fault = flt_q;

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  sequence s_chk_write_one;
    i_ce && i_reg_wr && i_reg_addr == `EMO_ADDR_CHK && i_reg_wdata[0];
  endsequence
  sequence s_rev_hit;
    i_ce && idx == EMO_IDX_REV && hit_now && !hit_q;
  endsequence

  a_chk_enable_write: assert property (s_chk_write_one |=> chk_q)
    else $error("overspeed enable did not take a written one");
  a_fault_needs_enable: assert property (
    o_output_overspeed_fault |-> $past(chk_q))
    else $error("overspeed fault raised while monitor disabled");
  a_fault_on_overspeed: assert property (
    i_ce && chk_q && fmt != EMO_FMT_OFF
    && need_q > PROD_W'(`EMO_CLK_HZ) |=> o_output_overspeed_fault)
    else $error("overspeed not flagged above derived limit");
  a_dir_write: assert property (
    i_ce && i_reg_wr && i_reg_addr == `EMO_ADDR_DIR
    |=> dir_q == $past(i_reg_wdata[0]))
    else $error("direction setting not stored");
  a_dir_xor: assert property (
    out_up == (i_fb_up ^ (i_drive_direction_bit != dir_q)))
    else $error("effective direction is not the xor of both bits");
  a_count_sense: assert property (
    i_drive_direction_bit != dir_q |-> out_up == !i_fb_up)
    else $error("differing bits did not reverse the count");
  a_mode_range: assert property (mode_q <= `EMO_MODE_MAX)
    else $error("mode selector left its legal range");
  a_rev_index: assert property (s_rev_hit |=> o_pulse_index)
    else $error("per-rev index missing at offset");
  a_abs_turn: assert property (
    i_ce && idx == EMO_IDX_ABS && i_turn != i_index_turn_setting
    |=> !o_pulse_index)
    else $error("absolute index outside its turn");
  a_idle_lines: assert property (
    i_ce && fmt == EMO_FMT_OFF ##1 i_ce && fmt == EMO_FMT_OFF
    |-> !o_pulse_a && !o_pulse_b && !o_pulse_index
    && !o_output_overspeed_fault)
    else $error("lines active in a non-output mode");
  a_pass_index: assert property (
    i_ce && idx == EMO_IDX_PASS |=> o_pulse_index == $past(i_phys_index))
    else $error("physical index not passed through");
endmodule : emo_ctrl
`default_nettype wire

// File: design/emo_pulse_gen.sv
// line pulse generator: quadrature, step/dir or cw/ccw from count steps
`timescale 1ns/1ns
`default_nettype none
module emo_pulse_gen
  import emo_pkg::*;
#(
  parameter int PW_W = 16
) (
  input wire logic i_clk, // control clock
  input wire logic i_rstn, // sync reset, active low
  input wire logic i_ce, // clock enable
  input wire emo_fmt_t i_fmt, // selected line format
  input wire logic [PW_W-1:0] i_pw, // pulse width in cycles
  input wire logic i_step, // one count step request
  input wire logic i_up, // step raises the output count
  output logic o_a, // line a
  output logic o_b, // line b
  output logic o_busy // pulse in progress
);
  logic [PW_W-1:0] cnt_q, cnt_d;
  logic [1:0] ph_q, ph_d;
  logic a_q, a_d, b_q, b_d;
  logic [PW_W-1:0] pw_eff;

  // a zero width would never end a pulse, so it counts as one cycle
  assign pw_eff = (i_pw == '0) ? PW_W'(1) : i_pw;

  // next state: steps that arrive while a pulse runs are dropped
  always_comb begin
    cnt_d = cnt_q;
    ph_d = ph_q;
    a_d = a_q;
    b_d = b_q;
    if (i_fmt == EMO_FMT_OFF) begin
      cnt_d = '0;
      a_d = 1'b0;
      b_d = 1'b0;
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - PW_W'(1);
      if (cnt_q == PW_W'(1) && i_fmt != EMO_FMT_QUAD) begin
        a_d = 1'b0;
        b_d = (i_fmt == EMO_FMT_STEPDIR) ? b_q : 1'b0;
      end
    end else if (i_step) begin
      cnt_d = pw_eff;
      case (i_fmt)
        EMO_FMT_QUAD: begin
          ph_d = i_up ? ph_q + 2'h1 : ph_q - 2'h1;
          a_d = ph_d[1];
          b_d = ph_d[1] ^ ph_d[0];
        end
        EMO_FMT_STEPDIR: begin
          a_d = 1'b1;
          b_d = i_up;
        end
        default: begin
          a_d = i_up;
          b_d = ~i_up;
        end
      endcase
    end
    // quadrature lines always show the phase, so entering that format
    // from another one cannot leave the lines out of step with it
    if (i_fmt == EMO_FMT_QUAD) begin
      a_d = ph_d[1];
      b_d = ph_d[1] ^ ph_d[0];
    end
  end

  // registers, frozen while the clock enable is low
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      cnt_q <= '0;
      ph_q <= 2'h0;
      a_q <= 1'b0;
      b_q <= 1'b0;
    end else if (i_ce) begin
      cnt_q <= cnt_d;
      ph_q <= ph_d;
      a_q <= a_d;
      b_q <= b_d;
    end
  end

  assign o_a = a_q;
  assign o_b = b_q;
  assign o_busy = (cnt_q != '0);
endmodule : emo_pulse_gen
`default_nettype wire

// File: shared/emo_defines.svh
// register offsets, reset values, mode limit and timing constants
`ifndef EMO_DEFINES_SVH
`define EMO_DEFINES_SVH
`define EMO_ADDR_DIR 12'h0F4
`define EMO_ADDR_MODE 12'h0F6
`define EMO_ADDR_CHK 12'h41C
`define EMO_DIR_RST 1'h0
`define EMO_MODE_RST 4'h0
`define EMO_CHK_RST 1'h0
`define EMO_MODE_MAX 4'hE
`define EMO_CLK_HZ 64'd100000000
`define EMO_EDGES_PER_LINE 64'd4
`endif

// File: shared/emo_pkg.sv
// types shared by the emulated pulse output control block
package emo_pkg;
  typedef enum logic [1:0] {
    EMO_FMT_OFF,
    EMO_FMT_QUAD,
    EMO_FMT_STEPDIR,
    EMO_FMT_CWCCW
  } emo_fmt_t;
  typedef enum logic [1:0] {
    EMO_IDX_NONE,
    EMO_IDX_REV,
    EMO_IDX_ABS,
    EMO_IDX_PASS
  } emo_idx_t;
endpackage : emo_pkg

// File: verif/emo_rx_model.sv
// external controller model: quadrature decoder counting the output lines
`timescale 1ns/1ns
`default_nettype none
module emo_rx_model (
  input wire logic i_clk, // control clock
  input wire logic i_rstn, // sync reset, active low
  input wire logic i_a, // line a from the block
  input wire logic i_b, // line b from the block
  output logic [15:0] o_count // decoded position count
);
  logic [1:0] ph_q;
  logic [1:0] ph_d;
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  ////////////////////////////////////////////////////////////////////////
  // phase from the gray pair; a jump of two is ambiguous and is ignored
  always_comb begin
    ph_d = {i_a, i_a ^ i_b};
    cnt_d = cnt_q;
    if (2'(ph_d - ph_q) == 2'h1)
      cnt_d = cnt_q + 16'h1;
    else if (2'(ph_d - ph_q) == 2'h3)
      cnt_d = cnt_q - 16'h1;
  end
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      ph_q <= 2'h0;
      cnt_q <= 16'h0;
    end else begin
      ph_q <= ph_d;
      cnt_q <= cnt_d;
    end
  end
  assign o_count = cnt_q; // count is only meaningful in quadrature modes
endmodule : emo_rx_model
`default_nettype wire

// File: verif/tb_emulated_encoder_output_ctrl.sv
// bench for the emulated encoder output control block
`timescale 1ns/1ns
`default_nettype none
`include "emo_defines.svh"
module tb_emulated_encoder_output_ctrl;
  logic clk = 1'h0, rstn = 1'h0, ce = 1'h1, wr = 1'h0, rd = 1'h0;
  logic fb_step = 1'h0, fb_up = 1'h0, drv = 1'h0, phys = 1'h0;
  logic [11:0] addr = 12'h0;
  logic [15:0] wdata = 16'h0, lines = 16'h3E8, pw = 16'h1;
  logic [15:0] off = 16'h1234, rpos = 16'h1235, vel = 16'h0;
  logic [31:0] tset = 32'h7, turn = 32'h0, e;
  logic [15:0] rdata, count, rl, rp;
  logic pa, pb, pidx, fault, chg, any;
  int bad_count = 0, samples_checked = 0, n;
  always #5 clk = ~clk;
  emo_ctrl i_dut (.i_clk(clk), .i_rstn(rstn), .i_ce(ce), .i_reg_addr(addr),
    .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
    .i_drive_direction_bit(drv), .i_lines_per_rev_setting(lines),
    .i_output_pulse_width_setting(pw), .i_index_offset_setting(off),
    .i_index_turn_setting(tset), .i_fb_step(fb_step), .i_fb_up(fb_up),
    .i_rev_pos(rpos), .i_turn(turn), .i_phys_index(phys),
    .i_velocity(vel), .o_pulse_a(pa), .o_pulse_b(pb),
    .o_pulse_index(pidx), .o_output_overspeed_fault(fault));
  emo_rx_model i_rx (.i_clk(clk), .i_rstn(rstn), .i_a(pa), .i_b(pb),
    .o_count(count));
  ////////////////////////////////////////////////////////////////////////
  // verdict and comparison helpers
  task stop_test;
    if (bad_count == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : stop_test
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("FAIL %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk
  // register strobe cycles; read data lands on the edge that takes it
  task wr_reg(input logic [11:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a; wdata <= d; wr <= 1'h1;
    @(posedge clk);
    wr <= 1'h0;
  endtask : wr_reg
  task rd_reg(input logic [11:0] a, input logic [15:0] x);
    @(posedge clk);
    addr <= a; rd <= 1'h1;
    @(posedge clk);
    rd <= 1'h0;
    #1 chk(rdata, x);
  endtask : rd_reg
  // one feedback step, watching the lines for four cycles after it
  task step(input logic up);
    logic [1:0] ab0;
    #1 ab0 = {pa, pb};
    chg = 1'h0;
    any = 1'h0;
    @(posedge clk);
    fb_step <= 1'h1; fb_up <= up;
    @(posedge clk);
    fb_step <= 1'h0;
    repeat (4) begin
      #1 chg |= ({pa, pb} !== ab0);
      any |= pa | pb;
      @(posedge clk);
    end
  endtask : step
  // index hits over six cycles; the physical index is held two cycles
  task idx_case(input logic [3:0] m, input logic [31:0] t,
                input logic [15:0] p, input logic ph, input int x);
    wr_reg(`EMO_ADDR_MODE, {12'h0, m});
    n = 0;
    @(posedge clk);
    turn <= t; rpos <= p; phys <= ph;
    for (int j = 0; j < 6; j++) begin
      @(posedge clk);
      if (j == 1) phys <= 1'h0;
      #1 n += (pidx === 1'h1);
    end
    @(posedge clk);
    rpos <= off + 16'h10;
    chk(n, x);
  endtask : idx_case
  // fault level once the two-cycle pipeline has settled
  function automatic logic ovs_exp(input logic [15:0] v, l, p);
    logic [63:0] pp;
    pp = (p == 16'h0) ? 64'h1 : 64'(p);
    return (64'(v) * 64'(l) * pp * `EMO_EDGES_PER_LINE) > `EMO_CLK_HZ;
  endfunction : ovs_exp
  task ovs(input logic [15:0] v, input logic x);
    @(posedge clk);
    vel <= v;
    repeat (4) @(posedge clk);
    #1 chk(fault, x);
  endtask : ovs
  ////////////////////////////////////////////////////////////////////////
  // a hang costs one mismatch; the run takes well under 3000 cycles
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    stop_test();
  end
  initial begin
    void'($urandom(78));
    repeat (12) @(posedge clk);
    rstn <= 1'h1;
    rd_reg(`EMO_ADDR_CHK, 16'h0);
    rd_reg(`EMO_ADDR_DIR, 16'h0);
    rd_reg(`EMO_ADDR_MODE, 16'h0);
    rd_reg(12'h0F8, 16'h0);
    // every selector code, including the refused one past the top
    for (int m = 0; m < 16; m++) begin
      wr_reg(`EMO_ADDR_MODE, 16'(m));
      rd_reg(`EMO_ADDR_MODE, (m > 14) ? 16'hE : 16'(m));
      step(1'h1);
      // a refused code leaves the last legal mode in force
      e = (((m > 14) ? 14 : m) inside {1, 2, 6, 7, 8, 9, 12, 13, 14});
      chk(e ? chg : any, e);
    end
    // writes while the clock enable is low are not taken
    ce <= 1'h0;
    wr_reg(`EMO_ADDR_MODE, 16'h5);
    ce <= 1'h1;
    rd_reg(`EMO_ADDR_MODE, 16'hE);
    // direction: all four bit pairs, random feedback moves in quadrature
    wr_reg(`EMO_ADDR_MODE, 16'h1);
    for (int k = 0; k < 4; k++) begin
      drv <= k[1];
      wr_reg(`EMO_ADDR_DIR, 16'(k & 1) | 16'hFE);
      rd_reg(`EMO_ADDR_DIR, 16'(k & 1));
      e = count;
      repeat (12) begin
        n = $urandom_range(1, 0);
        step(n[0]);
        e = (n[0] ^ k[1] ^ k[0]) ? e + 1 : e - 1;
      end
      chk(count, e[15:0]);
    end
    idx_case(4'h1, 32'h3, off, 1'h0, 1);
    idx_case(4'h6, 32'h3, off + 16'h1, 1'h0, 0);
    idx_case(4'h2, 32'h3, off, 1'h0, 0);
    idx_case(4'h9, 32'h7, off, 1'h0, 1);
    idx_case(4'hC, 32'h3, off + 16'h1, 1'h1, 2);
    idx_case(4'h0, 32'h7, off, 1'h1, 0);
    // overspeed: limit edge for 1000 lines at 5 cycles, then random
    wr_reg(`EMO_ADDR_MODE, 16'h1);
    pw <= 16'h5;
    ovs(16'd5000, 1'h0);
    wr_reg(`EMO_ADDR_CHK, 16'h1);
    ovs(16'd5000, 1'h0);
    ovs(16'd5001, 1'h1);
    repeat (10) begin
      rl = 16'($urandom_range(2000, 1));
      rp = 16'($urandom_range(20, 0));
      n = $urandom_range(30000, 0);
      @(posedge clk);
      lines <= rl;
      pw <= rp;
      ovs(16'(n), ovs_exp(16'(n), rl, rp));
    end
    // fixed setting so that full speed is surely over the limit
    @(posedge clk);
    lines <= 16'h3E8;
    pw <= 16'h5;
    ovs(16'hFFFF, 1'h1);
    wr_reg(`EMO_ADDR_MODE, 16'hA);
    ovs(16'hFFFF, 1'h0);
    wr_reg(`EMO_ADDR_MODE, 16'h1);
    wr_reg(`EMO_ADDR_CHK, 16'h0);
    ovs(16'hFFFF, 1'h0);
    stop_test();
  end
endmodule : tb_emulated_encoder_output_ctrl
`default_nettype wire
